// File: hw/bsc_cell.sv
// package of boundary scan constants and the single scan cell
`timescale 1ns/1ns
`default_nettype none

package bsc_pkg;
  // --------------------------------------------------------------
  // instruction codes
  // --------------------------------------------------------------
  localparam int IR_W = 6;
  localparam logic [5:0] OP_EXTEST = 6'h00;
  localparam logic [5:0] OP_SAMPLE = 6'h01;
  localparam logic [5:0] OP_IDCODE = 6'h02;
  localparam logic [5:0] OP_HIGHZ = 6'h03;
  localparam logic [5:0] OP_CLAMP = 6'h3e;
  localparam logic [5:0] OP_BYPASS = 6'h3f;
  // idcode is the instruction after test logic reset
  localparam logic [5:0] IR_RST = 6'h02;
  // --------------------------------------------------------------
  // chain make-up and register values
  // --------------------------------------------------------------
  localparam int N_OBS_IN = 30;
  localparam int N_TX_PAIR = 8;
  localparam int N_BIDIR = 15;
  localparam int ID_W = 32;
  // arbitrary identification value, lsb fixed at one
  localparam logic [31:0] ID_VALUE = 32'h0000_0001;
  localparam logic BYP_CAPTURE = 1'b0;
  localparam logic CELL_RST = 1'b0;
  localparam int SYNC_STAGES = 2;

  // instructions that hand the pins to the update latches
  function automatic logic drives_pins(input logic [5:0] op);
    drives_pins = (op == OP_EXTEST) || (op == OP_CLAMP);
  endfunction
endpackage

module bsc_cell #(
  parameter bit HAS_UPD = 1'b1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // strobes from the chain control
  input wire logic cap_en,
  input wire logic shift_en,
  input wire logic upd_en,
  // data
  input wire logic cap_d,
  input wire logic scan_in,
  output logic scan_out,
  output logic upd_q
);
  logic shift_ff;
  logic nxt_shift;

  assign nxt_shift = shift_en ? scan_in : (cap_en ? cap_d : shift_ff);
  assign scan_out = shift_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shift_ff <= bsc_pkg::CELL_RST;
    else
      shift_ff <= nxt_shift;
  end

  generate
    if (HAS_UPD)
    begin : g_upd
      logic upd_ff;
      // update on the falling test clock so skew cannot race the shift stage
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          upd_ff <= bsc_pkg::CELL_RST;
        else if (upd_en)
          upd_ff <= shift_ff;
      end
      assign upd_q = upd_ff;
    end
    else
    begin : g_obs
      // observe-only: nothing to drive
      assign upd_q = 1'b0;
    end
  endgenerate
endmodule

`default_nettype wire

// File: hw/bsc_chain.sv
// boundary scan data registers, chain and pin muxing
`timescale 1ns/1ns
`default_nettype none

module bsc_chain #(
  parameter int N_IN = bsc_pkg::N_OBS_IN,
  parameter int N_TX = bsc_pkg::N_TX_PAIR,
  parameter int N_BI = bsc_pkg::N_BIDIR
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // test port pins
  input wire logic tap_tck,
  input wire logic tap_tdi,
  output logic tap_tdo,
  output logic tap_tdo_oe,
  // tap controller state, same clock domain
  input wire logic tap_logic_reset,
  input wire logic tap_capture_dr,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  input wire logic tap_shift_ir,
  input wire logic tap_update_ir,
  input wire logic [bsc_pkg::IR_W-1:0] ir_next,
  input wire logic ir_serial,
  // current instruction
  output logic [bsc_pkg::IR_W-1:0] instr,
  // observed input pins
  input wire logic [N_IN-1:0] in_pad,
  // differential transmit pairs
  input wire logic [N_TX-1:0] tx_core,
  output logic [N_TX-1:0] tx_pad,
  // bidirectional pins
  input wire logic [N_BI-1:0] bi_core_out,
  input wire logic [N_BI-1:0] bi_core_oe,
  input wire logic [N_BI-1:0] bi_pad_in,
  output logic [N_BI-1:0] bi_pad_out,
  output logic [N_BI-1:0] bi_pad_oe
);
  // ------------------------------------------------------------
  // elaboration checks
  // ------------------------------------------------------------
  generate
    if (N_IN < 1 || N_TX < 1 || N_BI < 1)
    begin : g_bad
      $error("bsc_chain needs at least one cell of each kind");
    end
  endgenerate

  // cell layout: observe, transmit control, then enable/capture pairs
  localparam int B0 = N_IN + N_TX;
  localparam int NC = B0 + 2 * N_BI;
  localparam int NS = 2 + N_IN + N_BI;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [NS-1:0] s1_ff;
  logic [NS-1:0] s2_ff;
  logic tck_prev_ff;
  wire [NS-1:0] raw_pins = {tap_tck, tap_tdi, in_pad, bi_pad_in};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      tck_prev_ff <= 1'b0;
    end
    else
    begin
      s1_ff <= raw_pins;
      s2_ff <= s1_ff;
      tck_prev_ff <= s2_ff[NS-1];
    end
  end

  wire tck_s = s2_ff[NS-1];
  wire tdi_s = s2_ff[NS-2];
  wire [N_IN-1:0] in_s = s2_ff[N_BI +: N_IN];
  wire [N_BI-1:0] bi_in_s = s2_ff[N_BI-1:0];
  wire tck_rise = tck_s & ~tck_prev_ff;
  wire tck_fall = ~tck_s & tck_prev_ff;

  // ------------------------------------------------------------
  // instruction latch and decode
  // ------------------------------------------------------------
  logic [bsc_pkg::IR_W-1:0] instr_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      instr_ff <= bsc_pkg::IR_RST;
    else if (tap_logic_reset)
      instr_ff <= bsc_pkg::IR_RST;
    else if (tck_fall && tap_update_ir)
      instr_ff <= ir_next;
  end

  assign instr = instr_ff;

  wire is_extest = (instr_ff == bsc_pkg::OP_EXTEST);
  wire is_sample = (instr_ff == bsc_pkg::OP_SAMPLE);
  wire is_highz = (instr_ff == bsc_pkg::OP_HIGHZ);
  wire pin_ctrl = bsc_pkg::drives_pins(instr_ff);
  wire sel_chain = is_extest | is_sample;
  wire sel_id = (instr_ff == bsc_pkg::OP_IDCODE);
  // reserved, clamp, highz and bypass all take the one-bit path
  wire sel_byp = ~sel_chain & ~sel_id;

  wire do_cap = tck_rise & tap_capture_dr;
  wire do_shift = tck_rise & tap_shift_dr;
  wire do_upd = tck_fall & tap_update_dr;

  // ------------------------------------------------------------
  // bypass and identification registers
  // ------------------------------------------------------------
  logic byp_ff;
  logic [bsc_pkg::ID_W-1:0] id_ff;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      byp_ff <= bsc_pkg::BYP_CAPTURE;
    else if (sel_byp && do_shift)
      byp_ff <= tdi_s;
    else if (sel_byp && do_cap)
      byp_ff <= bsc_pkg::BYP_CAPTURE;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      id_ff <= bsc_pkg::ID_VALUE;
    else if (sel_id && do_shift)
      id_ff <= {tdi_s, id_ff[bsc_pkg::ID_W-1:1]};
    else if (sel_id && do_cap)
      id_ff <= bsc_pkg::ID_VALUE;
  end

  // ------------------------------------------------------------
  // boundary cells
  // ------------------------------------------------------------
  // nets: each bit has its own driver, a cell or a pin mux
  wire [NC-1:0] cap_d;
  wire [NC-1:0] upd_q;
  wire [NC-1:0] sc_out;
  wire [NC-1:0] sc_in = {sc_out[NC-2:0], tdi_s};
  wire c_cap = sel_chain & do_cap;
  wire c_shift = sel_chain & do_shift;
  // preload must also reach the latches, so update under both
  wire c_upd = sel_chain & do_upd;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi++)
    begin : g_cell
      bsc_cell #(
        .HAS_UPD(gi >= N_IN)
      ) u_cell (
        .clk(clk),
        .rst_n(rst_n),
        .cap_en(c_cap),
        .shift_en(c_shift),
        .upd_en(c_upd),
        .cap_d(cap_d[gi]),
        .scan_in(sc_in[gi]),
        .scan_out(sc_out[gi]),
        .upd_q(upd_q[gi])
      );
    end

    // observe cells sample their pin only
    assign cap_d[N_IN-1:0] = in_s;

    for (gi = 0; gi < N_TX; gi++)
    begin : g_tx
      // one control cell drives both legs of the pair
      assign tx_pad[gi] = pin_ctrl ? upd_q[N_IN+gi] : tx_core[gi];
      assign cap_d[N_IN+gi] = tx_pad[gi];
    end

    for (gi = 0; gi < N_BI; gi++)
    begin : g_bi
      localparam int OE = B0 + 2 * gi;
      localparam int DT = B0 + 2 * gi + 1;
      wire core_path;
      // enable cell overrides the core enable; highz forces it off
      assign bi_pad_oe[gi] = pin_ctrl ? upd_q[OE] : (~is_highz & bi_core_oe[gi]);
      assign bi_pad_out[gi] = pin_ctrl ? upd_q[DT] : bi_core_out[gi];
      assign cap_d[OE] = bi_pad_oe[gi];
      // single shared register: core output when enabled outside extest, else the pin
      assign core_path = ~is_extest & bi_pad_oe[gi];
      assign cap_d[DT] = core_path ? bi_core_out[gi] : bi_in_s[gi];
    end
  endgenerate

  // ------------------------------------------------------------
  // serial output
  // ------------------------------------------------------------
  logic tdo_ff;
  logic tdo_oe_ff;
  wire dr_out = sel_chain ? sc_out[NC-1] : (sel_id ? id_ff[0] : byp_ff);
  wire nxt_tdo = tap_shift_ir ? ir_serial : dr_out;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tdo_ff <= 1'b0;
      tdo_oe_ff <= 1'b0;
    end
    else if (tck_fall)
    begin
      tdo_ff <= nxt_tdo;
      tdo_oe_ff <= tap_shift_dr | tap_shift_ir;
    end
  end

  assign tap_tdo = tdo_ff;
  assign tap_tdo_oe = tdo_oe_ff;
endmodule

`default_nettype wire

// File: verif/bsc_chain_asserts.sv
// port assertions for the boundary scan chain
`timescale 1ns/1ns
`default_nettype none
module bsc_chain_asserts #(
  parameter int N_TX = 8,
  parameter int N_BI = 15
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // test port and controller state
  input wire logic tap_tck,
  input wire logic tap_tdo,
  input wire logic tap_tdo_oe,
  input wire logic tap_shift_dr,
  input wire logic tap_update_dr,
  input wire logic tap_shift_ir,
  input wire logic tap_update_ir,
  input wire logic tap_logic_reset,
  input wire logic [5:0] instr,
  // pins
  input wire logic [N_TX-1:0] tx_core,
  input wire logic [N_TX-1:0] tx_pad,
  input wire logic [N_BI-1:0] bi_core_out,
  input wire logic [N_BI-1:0] bi_core_oe,
  input wire logic [N_BI-1:0] bi_pad_out,
  input wire logic [N_BI-1:0] bi_pad_oe
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // under extest pins move only with an update
  wire ext = instr == bsc_pkg::OP_EXTEST;
  AST_TX_CORE: assert property (!ext && instr != bsc_pkg::OP_CLAMP |-> tx_pad == tx_core)
    else $error("tx pad off core");
  AST_BI_CORE: assert property (instr == bsc_pkg::OP_SAMPLE |-> bi_pad_oe == bi_core_oe && bi_pad_out == bi_core_out)
    else $error("bidir pad off core");
  AST_IR_UPD: assert property (!$stable(instr) |-> $past(tap_update_ir) || $past(tap_logic_reset) || tap_logic_reset)
    else $error("instr moved outside update");
  AST_EXT_TX: assert property (ext && $past(ext) && !$past(tap_update_dr) |-> $stable(tx_pad))
    else $error("tx pad moved in extest");
  AST_EXT_OE: assert property (ext && $past(ext) && !$past(tap_update_dr) |-> $stable(bi_pad_oe) && $stable(bi_pad_out))
    else $error("bidir pad moved in extest");
  AST_TDO_FALL: assert property ($changed(tap_tdo) |-> !$past(tap_tck) && !$past(tap_tck, 2))
    else $error("tdo moved off a falling edge");
  AST_OE_ON: assert property ($rose(tap_tdo_oe) |-> !$past(tap_tck) && ($past(tap_shift_dr) || $past(tap_shift_ir)))
    else $error("tdo enabled outside shift");
  AST_OE_OFF: assert property ($fell(tap_tdo_oe) |-> !$past(tap_shift_dr) && !$past(tap_shift_ir))
    else $error("tdo released in shift");
  C_EXT: cover property (ext && $past(tap_update_dr));
  C_SHIFT: cover property ($rose(tap_tdo_oe));
  C_SAMPLE: cover property (instr == bsc_pkg::OP_SAMPLE && tap_update_dr);
endmodule
`default_nettype wire

// File: verif/bsc_tap_model.sv
// test controller model for the scan port
`timescale 1ns/1ns
`default_nettype none
module bsc_tap_model (
  // clock
  input wire logic clk,
  // scan port
  input wire logic tap_tdo,
  output logic tap_tck,
  output logic tap_tdi,
  // state levels: reset, capture, shift, update, shift-ir, update-ir
  output logic [5:0] lv,
  output logic [5:0] ir_next
);
  initial
  begin
    tap_tck = 1'b0;
    tap_tdi = 1'b1;
    lv = 6'h00;
    ir_next = bsc_pkg::IR_RST;
  end
  // one tck period; levels move after the rise, as a real controller would
  task automatic step(input logic [5:0] l, input logic d, output logic q);
    tap_tck = 1'b1;
    repeat (3) @(negedge clk);
    q = tap_tdo;
    lv = l;
    tap_tdi = d;
    @(negedge clk);
    tap_tck = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  task automatic ir(input logic [5:0] op);
    logic b;
    ir_next = op;
    step(6'h01, 1'b1, b);
    step(6'h00, 1'b1, b);
  endtask
  // capture, n shifts, update; bits in tdo order
  task automatic dr(input int n, input logic [63:0] w, output logic [63:0] r);
    logic b;
    r = '0;
    step(6'h10, 1'b1, b);
    for (int j = 0; j < n; j++)
    begin
      step(6'h08, w[j], b);
      if (j > 0)
        r[j-1] = b;
    end
    step(6'h04, 1'b1, b);
    r[n-1] = b;
    step(6'h00, 1'b1, b);
  endtask
endmodule
`default_nettype wire

// File: verif/tb_top.sv
// self-checking bench for the boundary scan chain
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  // small chain keeps scans short
  localparam int NI = 2;
  localparam int NT = 2;
  localparam int NB = 2;
  localparam int L = NI + NT + 2 * NB;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tap_tck, tap_tdi, tap_tdo, tap_tdo_oe;
  logic ir_serial = 1'b0;
  logic [5:0] lv, ir_next, instr;
  logic [NI-1:0] in_pad;
  logic [NT-1:0] tx_core, tx_pad;
  logic [NB-1:0] bi_core_out, bi_core_oe, bi_pad_in, bi_pad_out, bi_pad_oe;
  logic [63:0] r, w;
  logic [L-1:0] c, lat;
  logic [5:0] ops [5] = '{6'h3f, 6'h3e, 6'h03, 6'h04, 6'h2d};
  int num_errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #10 clk = ~clk;
  bsc_tap_model ctl (.clk(clk), .tap_tdo(tap_tdo), .tap_tck(tap_tck), .tap_tdi(tap_tdi), .lv(lv), .ir_next(ir_next));
  bsc_chain #(.N_IN(NI), .N_TX(NT), .N_BI(NB)) dut (.clk(clk), .rst_n(rst_n), .tap_tck(tap_tck),
    .tap_tdi(tap_tdi), .tap_tdo(tap_tdo), .tap_tdo_oe(tap_tdo_oe), .tap_logic_reset(lv[5]),
    .tap_capture_dr(lv[4]), .tap_shift_dr(lv[3]), .tap_update_dr(lv[2]), .tap_shift_ir(lv[1]),
    .tap_update_ir(lv[0]), .ir_next(ir_next), .ir_serial(ir_serial), .instr(instr), .in_pad(in_pad),
    .tx_core(tx_core), .tx_pad(tx_pad), .bi_core_out(bi_core_out), .bi_core_oe(bi_core_oe),
    .bi_pad_in(bi_pad_in), .bi_pad_out(bi_pad_out), .bi_pad_oe(bi_pad_oe));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // model of what each cell captures, in tdo order
  function automatic logic [L-1:0] cap(input bit ext);
    logic [L-1:0] v;
    logic oe;
    v[NI-1:0] = in_pad;
    v[NI+NT-1:NI] = ext ? lat[NI+NT-1:NI] : tx_core;
    for (int k = 0; k < NB; k++)
    begin
      oe = ext ? lat[NI+NT+2*k] : bi_core_oe[k];
      v[NI+NT+2*k] = oe;
      v[NI+NT+2*k+1] = (oe && !ext) ? bi_core_out[k] : bi_pad_in[k];
    end
    return {<<{v}};
  endfunction
  task automatic pads(input bit ext);
    // pads are combinational: look one clock after the inputs moved
    @(negedge clk);
    chk(tx_pad, ext ? lat[NI+NT-1:NI] : tx_core);
    for (int k = 0; k < NB; k++)
    begin
      chk(bi_pad_oe[k], ext ? lat[NI+NT+2*k] : bi_core_oe[k]);
      chk(bi_pad_out[k], ext ? lat[NI+NT+2*k+1] : bi_core_out[k]);
    end
  endtask
  task automatic rnd();
    @(negedge clk);
    {in_pad, tx_core, bi_core_out, bi_core_oe, bi_pad_in} = 10'($urandom);
  endtask
  // one capture-shift-update pass with random fill, then latch model
  task automatic scan(input bit ext);
    rnd();
    pads(ext);
    w = 64'($urandom);
    c = cap(ext);
    ctl.dr(L, w, r);
    chk(r[L-1:0], c);
    lat = {<<{w[L-1:0]}};
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      close_out();
    end
  end
  initial
  begin
    {in_pad, tx_core, bi_core_out, bi_core_oe, bi_pad_in} = '0;
    lat = '0;
    void'($urandom(32'h2aae));
    repeat (3) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk(instr, bsc_pkg::IR_RST);
    chk(tap_tdo_oe, 1'b0);
    ctl.dr(bsc_pkg::ID_W, '1, r);
    chk(r[31:0], bsc_pkg::ID_VALUE);
    $display("test idcode done");
    foreach (ops[i])
    begin
      ctl.ir(ops[i]);
      chk(instr, ops[i]);
      rnd();
      @(negedge clk);
      chk(tx_pad, ops[i] == bsc_pkg::OP_CLAMP ? lat[NI+NT-1:NI] : tx_core);
      for (int k = 0; k < NB; k++)
        chk(bi_pad_oe[k], ops[i] == bsc_pkg::OP_HIGHZ ? 1'b0 : (ops[i] == bsc_pkg::OP_CLAMP ? lat[NI+NT+2*k] : bi_core_oe[k]));
      w = 64'($urandom);
      ctl.dr(3, w, r);
      chk(r[2:0], {w[1:0], 1'b0});
    end
    $display("test bypass done");
    ctl.ir(bsc_pkg::OP_SAMPLE);
    repeat (3) scan(1'b0);
    $display("test sample done");
    // random values are preloaded above before extest
    ctl.ir(bsc_pkg::OP_EXTEST);
    repeat (3) scan(1'b1);
    pads(1'b1);
    $display("test extest done");
    ctl.step(6'h20, 1'b1, r[0]);
    ctl.step(6'h00, 1'b1, r[0]);
    chk(instr, bsc_pkg::IR_RST);
    rnd();
    pads(1'b0);
    $display("test release done");
    // opposite of the last data bit, so tdo must come from the ir path
    ir_serial = ~tap_tdo;
    ctl.step(6'h02, 1'b1, r[0]);
    chk(tap_tdo_oe, 1'b1);
    ctl.step(6'h00, 1'b1, r[0]);
    chk(r[0], ir_serial);
    chk(tap_tdo_oe, 1'b0);
    $display("test shift-ir done");
    close_out();
  end
endmodule
bind bsc_chain bsc_chain_asserts #(.N_TX(N_TX), .N_BI(N_BI)) u_chk (.clk(clk), .rst_n(rst_n),
  .tap_tck(tap_tck), .tap_tdo(tap_tdo), .tap_tdo_oe(tap_tdo_oe), .tap_shift_dr(tap_shift_dr),
  .tap_update_dr(tap_update_dr), .tap_shift_ir(tap_shift_ir), .tap_update_ir(tap_update_ir),
  .tap_logic_reset(tap_logic_reset), .instr(instr), .tx_core(tx_core), .tx_pad(tx_pad),
  .bi_core_out(bi_core_out), .bi_core_oe(bi_core_oe), .bi_pad_out(bi_pad_out), .bi_pad_oe(bi_pad_oe));
`default_nettype wire
